// ### rtl/bmx_break_monitor.sv
// Breakpoint comparator, break-state gating and monitor-mode entry.
// Assumes an AHB-Lite master on sys_clk and an external pull-up on the serial pin.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bmx_break_monitor #(
    parameter int DIV_EXT = bmx_pkg::DIV_EXTERNAL,
    parameter int DIV_INT = bmx_pkg::DIV_INTERNAL
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire bmx_pkg::bmx_cpu_type cpu_fetch,
    input wire logic cpu_low_power,
    input wire logic cpu_wait_exit,
    input wire logic status_clear_req,
    input wire bmx_pkg::bmx_flash_type flash_bytes,
    input wire logic test_high_voltage,
    input wire logic irq_pin,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic serial_port_pin_in,
    output logic serial_port_pin_out,
    output logic serial_port_pin_oe_n,
    output logic breakpoint_signal,
    output logic [15:0] break_vector,
    output logic timer_halt,
    output logic watchdog_disable,
    output logic status_clear_allow,
    output logic monitor_mode,
    output logic internal_osc_select,
    output logic [7:0] oscillator_trim_value,
    output logic monitor_ready
);
    import bmx_pkg::*;

    // All properties below belong to the one bus clock and its reset.
    default clocking cb_sys @(posedge sys_clk); endclocking
    default disable iff (srst);

    // ****************************************
    // Elaboration checks.
    // ****************************************
    if (DIV_EXT < 4 || DIV_EXT > 511) begin : g_bad_ext
        $error("DIV_EXT must lie in 4..511");
    end
    if (DIV_INT < 4 || DIV_INT > 511) begin : g_bad_int
        $error("DIV_INT must lie in 4..511");
    end

    // Bus capture, break registers, pin chains and monitor serial state.
    logic ap_valid, ap_write, break_enable_flag, break_active_flag;
    logic break_disable_watchdog, wait_exit_by_break, clear_flag_enable;
    logic addr_match, wr_status, ser_prev, latch_pending, bit_tick, rx_busy;
    logic [7:0] ap_addr, break_address_high, break_address_low;
    logic [2:0] sync_tvh, sync_irq;
    logic [1:0] sync_ser;
    logic [8:0] baud_cnt, baud_top;
    logic [3:0] bit_cnt, byte_cnt;
    bmx_mon_state_type mon_state;

    // ****************************************
    // AHB-Lite slave.
    // ****************************************
    // Address phase is captured; zero wait states, always OKAY.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_valid <= hsel && hready && htrans[1] && hsize == 3'b010;
            ap_write <= hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    // Read data is fetched at the address phase so it stands from a flop.
    // Unmapped offsets, and haddr above bit 7 outside the map, read zero.
    function automatic logic [7:0] read_mux(input logic [31:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a[31:8] == 24'h00_0000) begin
            unique case (a[7:0])
                OFS_STATUS_CONTROL: d = {break_enable_flag, break_active_flag, 6'h00};
                OFS_ADDRESS_HIGH: d = break_address_high;
                OFS_ADDRESS_LOW: d = break_address_low;
                OFS_AUXILIARY: d = {7'h00, break_disable_watchdog};
                OFS_WAIT_STATUS: d = {6'h00, wait_exit_by_break, 1'b0};
                OFS_FLAG_CONTROL: d = {clear_flag_enable, 7'h00};
                default: d = 8'h00;
            endcase
        end
        return d;
    endfunction : read_mux

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= {24'h00_0000, read_mux(haddr)};
            end
        end
    end

    assign wr_status = ap_valid && ap_write && ap_addr == OFS_STATUS_CONTROL;

    // ****************************************
    // Breakpoint comparator and flags.
    // ****************************************
    // No match can occur in wait or stop: cpu_low_power masks the comparator there.
    assign addr_match = break_enable_flag && cpu_fetch.valid && !cpu_low_power
        && cpu_fetch.addr == {break_address_high, break_address_low};

    // Enable is written directly at bit 7; reset clears it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            break_enable_flag <= 1'b0;
        end else if (wr_status) begin
            break_enable_flag <= hwdata[BIT_BREAK_ENABLE];
        end
    end

    // A match sets the active flag even in the cycle software clears it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            break_active_flag <= 1'b0;
        end else if (addr_match) begin
            break_active_flag <= 1'b1;
        end else if (wr_status) begin
            break_active_flag <= hwdata[BIT_BREAK_ACTIVE];
        end
    end

    // Breakpoint address halves.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            break_address_high <= REG_RESET;
            break_address_low <= REG_RESET;
        end else if (ap_valid && ap_write) begin
            if (ap_addr == OFS_ADDRESS_HIGH) begin
                break_address_high <= hwdata[7:0];
            end
            if (ap_addr == OFS_ADDRESS_LOW) begin
                break_address_low <= hwdata[7:0];
            end
        end
    end

    // Auxiliary and flag-control bits.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            break_disable_watchdog <= 1'b0;
            clear_flag_enable <= 1'b0;
        end else if (ap_valid && ap_write) begin
            if (ap_addr == OFS_AUXILIARY) begin
                break_disable_watchdog <= hwdata[BIT_DISABLE_WATCHDOG];
            end
            if (ap_addr == OFS_FLAG_CONTROL) begin
                clear_flag_enable <= hwdata[BIT_CLEAR_ENABLE];
            end
        end
    end

    // Wait exit caused by a break; writing zero clears, a new event wins.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_exit_by_break <= 1'b0;
        end else if (cpu_wait_exit && (break_active_flag || addr_match)) begin
            wait_exit_by_break <= 1'b1;
        end else if (ap_valid && ap_write && ap_addr == OFS_WAIT_STATUS
                && !hwdata[BIT_WAIT_EXIT]) begin
            wait_exit_by_break <= 1'b0;
        end
    end

    // ****************************************
    // Break-state outputs.
    // ****************************************
    // The request follows the flag, so one match is held until cleared.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            breakpoint_signal <= 1'b0;
            timer_halt <= 1'b0;
            watchdog_disable <= 1'b0;
            status_clear_allow <= 1'b1;
            break_vector <= VEC_BREAK_USER;
        end else begin
            breakpoint_signal <= break_active_flag || addr_match;
            timer_halt <= break_active_flag || addr_match;
            watchdog_disable <= break_active_flag && monitor_mode
                && break_disable_watchdog;
            status_clear_allow <= !break_active_flag || clear_flag_enable
                || !status_clear_req;
            break_vector <= monitor_mode ? VEC_BREAK_MONITOR : VEC_BREAK_USER;
        end
    end

    // ****************************************
    // Pin synchronisers.
    // ****************************************
    // Third stage of the sync_tvh and sync_irq chains is only used for sampling after sync.
    always_ff @(posedge sys_clk) begin
        sync_tvh <= {sync_tvh[1:0], test_high_voltage};
        sync_irq <= {sync_irq[1:0], irq_pin};
        sync_ser <= {sync_ser[0], serial_port_pin_in};
        ser_prev <= sync_ser[1];
    end

    // ****************************************
    // Monitor-mode latch at reset release.
    // ****************************************
    // The pins are sampled once, at the first clock after release, from
    // synchronisers that still hold levels from during reset; later pin moves are ignored.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_pending <= 1'b1;
            monitor_mode <= 1'b0;
            internal_osc_select <= 1'b0;
            oscillator_trim_value <= TRIM_DEFAULT;
        end else if (latch_pending) begin
            latch_pending <= 1'b0;
            if (flash_bytes.vec_high == BLANK_BYTE && flash_bytes.vec_low == BLANK_BYTE) begin
                monitor_mode <= 1'b1;
                internal_osc_select <= !sync_irq[2];
                if (!sync_irq[2] && flash_bytes.trim != BLANK_BYTE) begin
                    oscillator_trim_value <= flash_bytes.trim;
                end
            end else begin
                monitor_mode <= sync_tvh[2];
            end
        end
    end

    // ****************************************
    // Monitor serial timing.
    // ****************************************
    assign baud_top = internal_osc_select ? 9'(DIV_INT - 1) : 9'(DIV_EXT - 1);

    // One bit tick per bit time; restarted on each start edge.
    always_ff @(posedge sys_clk) begin
        if (srst || (mon_state == MON_SECURITY && !rx_busy)) begin
            baud_cnt <= 9'h000;
            bit_tick <= 1'b0;
        end else if (baud_cnt == baud_top) begin
            baud_cnt <= 9'h000;
            bit_tick <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 9'h001;
            bit_tick <= 1'b0;
        end
    end

    // Security bytes are counted as whole frames; content is not checked here.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mon_state <= MON_OFF;
            rx_busy <= 1'b0;
            bit_cnt <= 4'h0;
            byte_cnt <= 4'h0;
            serial_port_pin_out <= 1'b0;
            serial_port_pin_oe_n <= 1'b1;
            monitor_ready <= 1'b0;
        end else begin
            unique case (mon_state)
                MON_OFF: begin
                    if (!latch_pending && monitor_mode) begin
                        mon_state <= MON_SECURITY;
                    end
                end
                MON_SECURITY: begin
                    if (!rx_busy) begin
                        if (ser_prev && !sync_ser[1]) begin
                            rx_busy <= 1'b1;
                            bit_cnt <= 4'h0;
                        end
                    end else if (bit_tick) begin
                        if (bit_cnt == FRAME_BITS - 4'h1) begin
                            rx_busy <= 1'b0;
                            byte_cnt <= byte_cnt + 4'h1;
                            if (byte_cnt == SECURITY_BYTES - 4'h1) begin
                                mon_state <= MON_BREAK;
                                serial_port_pin_oe_n <= 1'b0;
                                bit_cnt <= 4'h0;
                            end
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                MON_BREAK: begin
                    // Pin is only ever pulled low; the pull-up makes the high.
                    if (bit_tick) begin
                        if (bit_cnt == BREAK_BITS - 4'h1) begin
                            serial_port_pin_oe_n <= 1'b1;
                            mon_state <= MON_READY;
                            monitor_ready <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                MON_READY: begin
                    monitor_ready <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Assertions and covers.
    // ****************************************
    // Each property uses the default clock and reset from the top of the module.
    property p_match_sets;
        addr_match |=> break_active_flag ##1 breakpoint_signal;
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("match lost");
    property p_enable_clear;
        wr_status && !hwdata[BIT_BREAK_ENABLE] |=> !break_enable_flag;
    endproperty
    a_enable_clear: assert property (p_enable_clear) else $error("enable kept");
    property p_soft_break;
        wr_status && hwdata[BIT_BREAK_ACTIVE] |=> ##1 breakpoint_signal && timer_halt;
    endproperty
    a_soft_break: assert property (p_soft_break) else $error("no soft break");
    property p_addr_reset;
        $past(srst) |-> break_address_high == 8'h00 && break_address_low == 8'h00;
    endproperty
    a_addr_reset: assert property (p_addr_reset) else $error("addr not reset");
    property p_clear_gate;
        break_active_flag && !clear_flag_enable && status_clear_req |=> !status_clear_allow;
    endproperty
    a_clear_gate: assert property (p_clear_gate) else $error("clear leaked");
    property p_wdog;
        watchdog_disable |-> $past(break_active_flag && break_disable_watchdog) && monitor_mode;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog wrong");
    property p_low_power;
        cpu_low_power && !break_active_flag && !wr_status |=> !break_active_flag;
    endproperty
    a_low_power: assert property (p_low_power) else $error("match in sleep");
    property p_latch_hold;
        !latch_pending && !$past(latch_pending) |-> $stable(monitor_mode);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("mode moved");
    property p_break_hold;
        $rose(breakpoint_signal) && !wr_status |=> breakpoint_signal;
    endproperty
    a_break_hold: assert property (p_break_hold) else $error("request dropped");
    property p_vector;
        ##1 monitor_mode && $stable(monitor_mode) |-> break_vector == VEC_BREAK_MONITOR;
    endproperty
    a_vector: assert property (p_vector) else $error("vector wrong");
    c_match: cover property (addr_match);
    c_break_tx: cover property ($fell(serial_port_pin_oe_n));
    c_ready: cover property ($rose(monitor_ready));
endmodule : bmx_break_monitor

// ### rtl/bmx_pkg.sv
// Constants and carriers for the breakpoint and monitor entry block.
// Assumes a single 50 MHz bus clock and an AHB-Lite register port.
package bmx_pkg;
    // ****************************************
    // Register map and fields.
    // ****************************************
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ADDRESS_HIGH = 8'h04;
    localparam logic [7:0] OFS_ADDRESS_LOW = 8'h08;
    localparam logic [7:0] OFS_AUXILIARY = 8'h0C;
    localparam logic [7:0] OFS_WAIT_STATUS = 8'h10;
    localparam logic [7:0] OFS_FLAG_CONTROL = 8'h14;
    localparam int BIT_BREAK_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_DISABLE_WATCHDOG = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_CLEAR_ENABLE = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ****************************************
    // Vectors, flash values and monitor timing.
    // ****************************************
    localparam logic [15:0] VEC_BREAK_USER = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK_MONITOR = 16'hFEFC;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [7:0] TRIM_DEFAULT = 8'h80;
    localparam logic [3:0] SECURITY_BYTES = 4'h8;
    localparam logic [3:0] BREAK_BITS = 4'hA;
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam int DIV_EXTERNAL = 256;
    localparam int DIV_INTERNAL = 335;
    // ****************************************
    // Carriers.
    // ****************************************
    typedef struct packed {
        logic [15:0] addr;
        logic valid;
    } bmx_cpu_type;
    typedef struct packed {
        logic [7:0] vec_high;
        logic [7:0] vec_low;
        logic [7:0] trim;
    } bmx_flash_type;
    typedef enum logic [1:0] {
        MON_OFF = 2'b00,
        MON_SECURITY = 2'b01,
        MON_BREAK = 2'b10,
        MON_READY = 2'b11
    } bmx_mon_state_type;
endpackage : bmx_pkg

// ### tb/bmx_host_model.sv
// Host side of the monitor serial link: sends eight frames, then times the device's break reply.
// Assumes the testbench resolves the wired line with a pull-up and feeds the level back here.
`timescale 1ns/1ps
module bmx_host_model #(
    parameter int BIT = 11
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic line_level,
    output logic host_drive,
    output logic done,
    output int low_count
);
    // ****************************************
    // Frame sender and break timer.
    // ****************************************
    // Frames are start, eight data bits and stop; an idle bit keeps frames apart.
    initial begin
        logic [9:0] frame;
        host_drive = 1'b1;
        done = 1'b0;
        low_count = 0;
        @(negedge srst);
        repeat (20) @(posedge sys_clk);
        for (int f = 0; f < 8; f++) begin
            frame = {1'b1, 8'h5A + 8'(f), 1'b0};
            // The idle bit leads each frame, so the host listens right after the last stop bit.
            host_drive <= 1'b1;
            repeat (BIT) @(posedge sys_clk);
            for (int b = 0; b < 10; b++) begin
                host_drive <= frame[b];
                repeat (BIT) @(posedge sys_clk);
            end
        end
        // The device must pull the line low; the host only listens from here on.
        while (line_level === 1'b1) @(posedge sys_clk);
        while (line_level === 1'b0) begin
            low_count++;
            @(posedge sys_clk);
        end
        done = 1'b1;
    end
endmodule : bmx_host_model

// ### tb/tb_top.sv
// Self-checking bench for the breakpoint and monitor entry block over AHB-Lite.
// Assumes the host model on the serial pin and a blank reset vector in flash.
`timescale 1ns/1ps
module tb_top;
    import bmx_pkg::*;
    localparam int DIV_I = 11;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    bmx_cpu_type cpu_fetch = '0;
    logic cpu_low_power = 1'b0, cpu_wait_exit = 1'b0, status_clear_req = 1'b0;
    bmx_flash_type flash_bytes = '{8'hFF, 8'hFF, 8'h5A};
    logic irq_pin = 1'b0, mode_pin_a = 1'b1, mode_pin_b = 1'b0, tvh = 1'b0;
    logic ser_out, ser_oe_n, host_drive, line, host_done, breakpoint_unit, halt, wdog, allow, mon, osc, rdy;
    logic [15:0] vec;
    logic [7:0] trim;
    int low_count, errors = 0, n_compared = 0;
    // ****************************************
    // Clock, wire resolution and instances.
    // ****************************************
    // The clock toggles every 10 ns, a period of 20 ns.
    always #10 sys_clk = ~sys_clk;
    assign hready = hreadyout;
    // Pull-up: the line is low only when some party pulls it.
    assign line = host_drive & (ser_oe_n | ser_out);
    bmx_break_monitor #(.DIV_EXT(8), .DIV_INT(DIV_I)) dut_u (.sys_clk(sys_clk), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cpu_fetch(cpu_fetch), .cpu_low_power(cpu_low_power),
        .cpu_wait_exit(cpu_wait_exit), .status_clear_req(status_clear_req),
        .flash_bytes(flash_bytes), .test_high_voltage(tvh), .irq_pin(irq_pin),
        .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .serial_port_pin_in(line),
        .serial_port_pin_out(ser_out), .serial_port_pin_oe_n(ser_oe_n),
        .breakpoint_signal(breakpoint_unit), .break_vector(vec), .timer_halt(halt),
        .watchdog_disable(wdog), .status_clear_allow(allow), .monitor_mode(mon),
        .internal_osc_select(osc), .oscillator_trim_value(trim), .monitor_ready(rdy));
    bmx_host_model #(.BIT(DIV_I)) host_u (.sys_clk(sys_clk), .srst(srst), .line_level(line),
        .host_drive(host_drive), .done(host_done), .low_count(low_count));
    // ****************************************
    // Bus, compare and report tasks.
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One single transfer: address phase until hready, then data phase until hready.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus
    task automatic fetch(input logic [15:0] a, input logic lp);
        @(posedge sys_clk);
        cpu_fetch <= '{a, 1'b1};
        cpu_low_power <= lp;
        @(posedge sys_clk);
        cpu_fetch <= '0;
        cpu_low_power <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : fetch
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // A hang is cut short well after the serial exchange should have ended.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        final_report();
    end
    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        // The mode pins move after the latch and must have no effect.
        mode_pin_a <= 1'b0;
        mode_pin_b <= 1'b1;
        settle();
        chk(mon, 1'b1);
        chk(osc, 1'b1);
        chk(trim, 8'h5A);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), '0);
            chk(rd, '0);
        end
        $display("test reset_values done");
        bus(1'b1, OFS_ADDRESS_HIGH, 32'h0000_0012);
        bus(1'b1, OFS_ADDRESS_LOW, 32'h0000_0034);
        bus(1'b1, OFS_STATUS_CONTROL, 32'h0000_0080);
        bus(1'b0, OFS_ADDRESS_LOW, '0);
        chk(rd, 32'h0000_0034);
        fetch(16'h1234, 1'b1);
        chk(breakpoint_unit, 1'b0);
        fetch(16'h1235, 1'b0);
        chk(breakpoint_unit, 1'b0);
        fetch(16'h1234, 1'b0);
        chk({breakpoint_unit, halt}, 2'b11);
        chk(vec, VEC_BREAK_MONITOR);
        bus(1'b0, OFS_STATUS_CONTROL, '0);
        chk(rd, 32'h0000_00C0);
        $display("test address_match done");
        bus(1'b1, OFS_AUXILIARY, 32'h0000_0001);
        status_clear_req <= 1'b1;
        settle();
        chk(wdog, 1'b1);
        chk(allow, 1'b0);
        bus(1'b1, OFS_FLAG_CONTROL, 32'h0000_0080);
        settle();
        chk(allow, 1'b1);
        cpu_wait_exit <= 1'b1;
        @(posedge sys_clk);
        cpu_wait_exit <= 1'b0;
        bus(1'b0, OFS_WAIT_STATUS, '0);
        chk(rd, 32'h0000_0002);
        bus(1'b1, OFS_STATUS_CONTROL, 32'h0000_0080);
        settle();
        chk({breakpoint_unit, halt, wdog}, 3'b000);
        $display("test break_gating done");
        bus(1'b1, OFS_STATUS_CONTROL, 32'h0000_0040);
        settle();
        chk(breakpoint_unit, 1'b1);
        bus(1'b1, OFS_STATUS_CONTROL, '0);
        bus(1'b1, 8'h18, 32'h0000_00FF);
        bus(1'b0, 8'h18, '0);
        chk(rd, '0);
        bus(1'b0, OFS_STATUS_CONTROL, '0);
        chk(rd, '0);
        chk(breakpoint_unit, 1'b0);
        fetch(16'h1234, 1'b0);
        chk(breakpoint_unit, 1'b0);
        $display("test software_break done");
        while (host_done !== 1'b1) @(posedge sys_clk);
        chk(low_count, 10 * DIV_I);
        chk(rdy, 1'b1);
        chk({hresp, ser_out}, 2'b00);
        $display("test monitor_link done");
        // A programmed vector needs the test voltage during reset for monitor entry.
        flash_bytes <= '{8'h12, 8'h34, 8'h5A};
        tvh <= 1'b1;
        srst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        chk({mon, osc, trim}, {2'b10, TRIM_DEFAULT});
        bus(1'b0, OFS_ADDRESS_LOW, '0);
        chk(rd, '0);
        tvh <= 1'b0;
        settle();
        chk(mon, 1'b1);
        $display("test programmed_entry done");
        final_report();
    end
endmodule : tb_top
